// [wdsp_pkg.sv]
// constants for the protected watchdog: register map, field positions, counts
// assumes an 8-bit register port with a 16-bit address
package wdsp_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [15:0] ADDR_REFRESH = 16'h0000;
    localparam logic [15:0] ADDR_START = 16'h0001;
    localparam logic [15:0] ADDR_PROT_CTRL = 16'h0002;
    localparam logic [15:0] ADDR_CLK_MODE1 = 16'h0003;
    localparam logic [15:0] ADDR_PROC_MODE1 = 16'h0004;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'h0005;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h0006;
    localparam logic [15:0] ADDR_COUNT_LO = 16'h0007;
    localparam logic [15:0] ADDR_COUNT_HI = 16'h0008;
    localparam logic [15:0] ADDR_OPTION = 16'hffff;

    // ****************************************
    // field positions
    // ****************************************
    localparam int PROT_EN_POS = 7;       // protection_enable_bit in protection_ctrl_reg
    localparam int PROT_ON_POS = 0;       // protection_on_flag (read only)
    localparam int ALL_STOP_POS = 0;      // all_clock_stop_bit in clock_mode_reg1
    localparam int SLOW_STOP_POS = 4;     // slow_osc_stop_bit in clock_mode_reg1
    localparam int UF_RST_SEL_POS = 2;    // underflow_reset_select in proc_mode_reg1
    localparam int OPT_PROT_INIT_POS = 7; // protection_init_bit of startup_option_byte
    localparam int OPT_AUTOSTART_POS = 0; // autostart_disable_bit of startup_option_byte
    localparam int IRQ_UNDERFLOW_POS = 0;
    localparam int IRQ_REFRESH_POS = 1;
    localparam int IRQ_BLOCKED_POS = 2;
    localparam int IRQ_BITS = 3;

    // ****************************************
    // values and counts
    // ****************************************
    localparam logic [7:0] REFRESH_FIRST = 8'h00;
    localparam logic [7:0] REFRESH_SECOND = 8'hff;
    localparam int WDT_PERIOD = 4096;
    localparam logic [11:0] WDT_RELOAD = 12'hfff;
    localparam logic [7:0] CLK_MODE1_RST = 8'h00;
    localparam logic [7:0] PROC_MODE1_RST = 8'h00;
    localparam logic [IRQ_BITS-1:0] IRQ_MASK_RST = 3'h0;

endpackage

// [wdsp_sync.sv]
// three-flop synchroniser with agreement filter and rising-edge pulse
// assumes the input is asynchronous to clk and slower than clk/4
`timescale 1ns/10ps
`default_nettype none
module wdsp_sync (
    input wire logic clk,        // system clock
    input wire logic rst_n,      // async reset, active low
    input wire logic ce,         // clock enable
    input wire logic async_in,   // pin level
    output logic level,          // filtered level
    output logic rise            // one-cycle pulse on filtered rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // ****************************************
    // sampling chain
    // ****************************************
    // s1 feeds only s2, to keep metastability out of the filter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else if (ce) begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // level only moves once the second and third stage agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_r <= 1'b0;
        end else if (ce && (s2_r == s3_r)) begin
            level_r <= s3_r;
        end
    end

    assign level = level_r;
    assign rise = ce && (s2_r == s3_r) && s3_r && !level_r;
endmodule
`default_nettype wire

// [wdsp_cnt.sv]
// down counter with load, count enable and underflow indication
// assumes load and enable come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module wdsp_cnt #(
    parameter int W = 12
) (
    input wire logic clk,           // system clock
    input wire logic rst_n,         // async reset, active low
    input wire logic ce,            // clock enable
    input wire logic load,          // reload request
    input wire logic [W-1:0] init,  // reload value
    input wire logic dec,           // one count
    output logic [W-1:0] count,     // current value
    output logic underflow          // pulse: count leaving zero
);
    logic [W-1:0] cnt_r;

    // ****************************************
    // counter
    // ****************************************
    // underflow reloads so the next period starts at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '1;
        end else if (ce) begin
            if (load || underflow) begin
                cnt_r <= init;
            end else if (dec) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign count = cnt_r;
    assign underflow = ce && dec && !load && (cnt_r == '0);
endmodule
`default_nettype wire

// [wdsp_top.sv]
// watchdog with count source protection, register port and interrupt
// assumes slow_osc_clk is the low-speed oscillator arriving as a pin,
// and option_byte is the static flash option byte
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

// Contract
// R01: in protection mode the counter is clocked from the slow oscillator
// R02: counter decrements, 4096 slow-oscillator counts per period
// R03: refresh by 00h then FFh; also reinit on reset and underflow
// R04: in protection mode an underflow resets the chip, no interrupt
// R05: autostart option 1 keeps counter stopped until start register written
// R06: autostart option 0 starts counting as soon as reset ends
// R07: once started in protection mode, wait mode does not halt counting
// R08: setting protection enable loads 0FFFh into the counter
// R09: setting protection enable clears the slow oscillator stop bit
// R10: setting protection enable sets the underflow reset select bit
// R11: in protection mode writes of 1 to all-clock-stop are ignored
// R12: in protection mode writes of 1 to slow-oscillator stop are ignored
// R13: protection init option 0 forces protection enable to 1
// R14: autostart option bit is not writable by software
// R15: protection init option bit is not writable by software
// R16: refresh only when FFh directly follows 00h to the refresh register
module wdsp_top
    import wdsp_pkg::*;
#(
    parameter int CNT_W = 12
) (
    input wire logic clk,                // system clock, 50 MHz
    input wire logic rst_n,              // async reset, active low
    input wire logic ce,                 // clock enable, freezes all state
    input wire logic slow_osc_clk,       // low-speed oscillator pin
    input wire logic [7:0] option_byte,  // flash option byte, static
    input wire logic wait_mode,          // cpu in wait mode
    input wire logic [15:0] addr,        // register address
    input wire logic [7:0] wdata,        // write data
    input wire logic wr,                 // write strobe
    input wire logic rd,                 // read strobe
    output logic [7:0] rdata,            // read data, cycle after rd
    output logic irq,                    // level interrupt
    output logic wdt_reset,              // one-cycle chip reset request
    output logic prot_on,                // protection mode active
    output logic all_clock_stop,         // stop mode request bit
    output logic slow_osc_stop           // slow oscillator off request
);

    // ****************************************
    // declarations
    // ****************************************
    logic [7:0] rdata_r;
    logic irq_r;
    logic wdt_reset_r;
    logic prot_r;
    logic prot_d_r;
    logic all_stop_r;
    logic slow_stop_r;
    logic uf_rst_sel_r;
    logic [7:0] opt_r;
    logic opt_valid_r;
    logic run_r;
    logic armed_r;
    logic [IRQ_BITS-1:0] stat_r;
    logic [IRQ_BITS-1:0] stat_nxt;
    logic [IRQ_BITS-1:0] mask_r;
    logic [IRQ_BITS-1:0] ev_set;
    logic [IRQ_BITS-1:0] ev_clr;
    logic osc_level;
    logic osc_tick;
    logic [CNT_W-1:0] count;
    logic underflow;
    logic refresh_ok;
    logic prot_rise;
    logic cnt_load;
    logic cnt_dec;
    logic blocked_wr;
    logic wr_refresh;
    logic wr_clk_mode;

    // full 16-bit address equality match, used by every write decode
    function automatic logic hit(input logic [15:0] a, input logic [15:0] want);
        hit = (a == want);
    endfunction

    // ****************************************
    // slow oscillator tick and counter
    // ****************************************
    // the slow oscillator is sampled, not used as a clock, so the
    // counter survives a stopped cpu clock only if clk itself survives
    wdsp_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(slow_osc_clk),
        .level(osc_level),
        .rise(osc_tick)
    );

    // count only on slow oscillator edges [R01]
    // wait mode halts the count only outside protection mode [R07]
    assign cnt_dec = run_r && osc_tick && (prot_r || !wait_mode); // [R01] [R07]
    // reload on refresh and on entering protection [R03] [R08]
    assign cnt_load = refresh_ok || prot_rise; // [R03] [R08]

    // decrement from 0fffh gives 4096 counts to underflow [R02]
    wdsp_cnt #(
        .W(CNT_W)
    ) u_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .load(cnt_load),
        .init(WDT_RELOAD[CNT_W-1:0]),
        .dec(cnt_dec),
        .count(count),
        .underflow(underflow)
    );

    // ****************************************
    // option byte capture
    // ****************************************
    // option byte is latched once after reset release; software has
    // no write path to it at all [R14] [R15]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_r <= 8'hff;
            opt_valid_r <= 1'b0;
        end else if (ce && !opt_valid_r) begin
            opt_r <= option_byte; // [R14] [R15]
            opt_valid_r <= 1'b1;
        end
    end

    // ****************************************
    // run control
    // ****************************************
    // autostart option 0 starts counting right after capture [R06];
    // option 1 waits for a write to the start register [R05]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 1'b0;
        end else if (ce) begin
            if (opt_valid_r && !opt_r[OPT_AUTOSTART_POS]) begin
                run_r <= 1'b1; // [R06]
            end else if (wr && hit(addr, ADDR_START)) begin
                run_r <= 1'b1; // [R05]
            end
        end
    end

    // ****************************************
    // refresh sequence
    // ****************************************
    assign wr_refresh = wr && hit(addr, ADDR_REFRESH);
    // only ffh right after 00h counts [R16]
    assign refresh_ok = wr_refresh && armed_r && (wdata == REFRESH_SECOND); // [R03] [R16]

    // any other write to the refresh register disarms
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (ce && wr_refresh) begin
            armed_r <= (wdata == REFRESH_FIRST); // [R16]
        end
    end

    // ****************************************
    // protection enable
    // ****************************************
    // once set it stays until reset; a cleared init option forces it [R13]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prot_r <= 1'b0;
        end else if (ce) begin
            if (opt_valid_r && !opt_r[OPT_PROT_INIT_POS]) begin
                prot_r <= 1'b1; // [R13]
            end else if (wr && hit(addr, ADDR_PROT_CTRL) && wdata[PROT_EN_POS]) begin
                prot_r <= 1'b1;
            end
        end
    end

    // delayed copy to find the moment protection switches on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prot_d_r <= 1'b0;
        end else if (ce) begin
            prot_d_r <= prot_r;
        end
    end

    assign prot_rise = prot_r && !prot_d_r;

    // ****************************************
    // clock and processor mode bits
    // ****************************************
    assign wr_clk_mode = wr && hit(addr, ADDR_CLK_MODE1);
    // a write of 1 to either stop bit in protection mode is dropped
    assign blocked_wr = wr_clk_mode && prot_r &&
        (wdata[ALL_STOP_POS] || wdata[SLOW_STOP_POS]);

    // all-clock-stop: writes of 1 ignored while protected [R11]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            all_stop_r <= CLK_MODE1_RST[ALL_STOP_POS];
        end else if (ce && wr_clk_mode) begin
            if (!(prot_r && wdata[ALL_STOP_POS])) begin
                all_stop_r <= wdata[ALL_STOP_POS]; // [R11]
            end
        end
    end

    // slow oscillator stop: cleared on entry [R09], 1 ignored while on [R12]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_stop_r <= CLK_MODE1_RST[SLOW_STOP_POS];
        end else if (ce) begin
            if (prot_rise) begin
                slow_stop_r <= 1'b0; // [R09]
            end else if (wr_clk_mode && !(prot_r && wdata[SLOW_STOP_POS])) begin
                slow_stop_r <= wdata[SLOW_STOP_POS]; // [R12]
            end
        end
    end

    // underflow reset select: forced to 1 while protected [R10]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uf_rst_sel_r <= PROC_MODE1_RST[UF_RST_SEL_POS];
        end else if (ce) begin
            if (prot_r) begin
                uf_rst_sel_r <= 1'b1; // [R10]
            end else if (wr && hit(addr, ADDR_PROC_MODE1)) begin
                uf_rst_sel_r <= wdata[UF_RST_SEL_POS];
            end
        end
    end

    // ****************************************
    // underflow action
    // ****************************************
    // reset request when selected; protection always selects it [R04]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_reset_r <= 1'b0;
        end else if (ce) begin
            wdt_reset_r <= underflow && (uf_rst_sel_r || prot_r); // [R04]
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // underflow only raises an interrupt when it does not reset [R04]
    always_comb begin
        ev_set = '0;
        ev_set[IRQ_UNDERFLOW_POS] = underflow && !uf_rst_sel_r && !prot_r; // [R04]
        ev_set[IRQ_REFRESH_POS] = refresh_ok;
        ev_set[IRQ_BLOCKED_POS] = blocked_wr;
        ev_clr = '0;
        if (wr && hit(addr, ADDR_IRQ_STAT)) begin
            ev_clr = wdata[IRQ_BITS-1:0];
        end
        // a new event beats a clear in the same cycle
        stat_nxt = (stat_r & ~ev_clr) | ev_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= '0;
        end else if (ce) begin
            stat_r <= stat_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= IRQ_MASK_RST;
        end else if (ce && wr && hit(addr, ADDR_IRQ_MASK)) begin
            mask_r <= wdata[IRQ_BITS-1:0];
        end
    end

    // registered from stat_nxt, so it changes in the same cycle as the status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(stat_nxt & mask_r);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    // data stands only in the cycle after the strobe; unmapped reads 00h
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= 8'h00;
            if (rd) begin
                unique case (addr)
                    ADDR_PROT_CTRL: begin
                        rdata_r[PROT_EN_POS] <= prot_r;
                        rdata_r[PROT_ON_POS] <= prot_r;
                    end
                    ADDR_CLK_MODE1: begin
                        rdata_r[ALL_STOP_POS] <= all_stop_r;
                        rdata_r[SLOW_STOP_POS] <= slow_stop_r;
                    end
                    ADDR_PROC_MODE1: rdata_r[UF_RST_SEL_POS] <= uf_rst_sel_r;
                    ADDR_IRQ_STAT: rdata_r[IRQ_BITS-1:0] <= stat_r;
                    ADDR_IRQ_MASK: rdata_r[IRQ_BITS-1:0] <= mask_r;
                    ADDR_COUNT_LO: rdata_r <= count[7:0];
                    ADDR_COUNT_HI: rdata_r[CNT_W-9:0] <= count[CNT_W-1:8];
                    ADDR_OPTION: rdata_r <= opt_r;
                    default: rdata_r <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata = rdata_r;
    assign irq = irq_r;
    assign wdt_reset = wdt_reset_r;
    assign prot_on = prot_d_r;
    assign all_clock_stop = all_stop_r;
    assign slow_osc_stop = slow_stop_r;

endmodule
`default_nettype wire

// [wdsp_chk.sv]
// checker for the protected watchdog: port-level relations over time
// assumes it is bound to wdsp_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module wdsp_chk
    import wdsp_pkg::*;
(
    input wire logic clk,               // system clock
    input wire logic rst_n,             // async reset, active low
    input wire logic [7:0] option_byte, // flash option byte
    input wire logic [15:0] addr,       // register address
    input wire logic [7:0] wdata,       // write data
    input wire logic wr,                // write strobe
    input wire logic rd,                // read strobe
    input wire logic [7:0] rdata,       // read data
    input wire logic wdt_reset,         // chip reset request
    input wire logic prot_on,           // protection active
    input wire logic all_clock_stop,    // stop mode bit
    input wire logic slow_osc_stop      // slow oscillator stop bit
);
    // ****************************************
    // sequences and properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // enabling write to the protection control register
    sequence s_prot_write;
        wr && addr == ADDR_PROT_CTRL && wdata[PROT_EN_POS];
    endsequence
    // a clock-mode write that tries to set a guarded bit while protected
    sequence s_stop_try;
        prot_on && wr && addr == ADDR_CLK_MODE1 && wdata[ALL_STOP_POS] && !all_clock_stop;
    endsequence
    sequence s_slow_try;
        prot_on && wr && addr == ADDR_CLK_MODE1 && wdata[SLOW_STOP_POS] && !slow_osc_stop;
    endsequence

    chk_reset_one_cycle: assert property (wdt_reset |=> !wdt_reset)
        else $error("reset request longer than one cycle");
    // a reload after underflow leaves a long quiet gap before the next one
    chk_reload_gap: assert property (wdt_reset |=> !wdt_reset [*8])
        else $error("second reset request too soon after underflow");
    chk_stop_ignored: assert property (s_stop_try |=> !all_clock_stop)
        else $error("all clock stop set while protected");
    chk_slow_ignored: assert property (s_slow_try |=> !slow_osc_stop)
        else $error("slow oscillator stop set while protected");
    chk_slow_cleared: assert property ($rose(prot_on) |-> !slow_osc_stop)
        else $error("slow oscillator stop still set on entering protection");
    chk_prot_enters: assert property (s_prot_write |-> ##[1:2] prot_on)
        else $error("protection not active after enable write");
    chk_prot_sticky: assert property (prot_on |=> prot_on)
        else $error("protection dropped without reset");
    chk_option_read: assert property (rd && addr == ADDR_OPTION |=> rdata == option_byte)
        else $error("option byte read back wrong");

    cover property (s_prot_write);
    cover property (wdt_reset);
endmodule
`default_nettype wire

// [wdsp_top_bench.sv]
// self-checking bench for the protected watchdog
// assumes the register port answers reads one cycle later; slow clock is a pin
`timescale 1ns/10ps
`default_nettype none
module wdsp_top_bench;
    import wdsp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic slow_osc_clk = 1'b0;
    logic [7:0] option_byte = 8'hff;
    logic wait_mode = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic irq, wdt_reset, prot_on, all_clock_stop, slow_osc_stop;
    int n_fail = 0;
    int n_tests = 0;
    int n_rst = 0;

    // ****************************************
    // clock, design, reset counter
    // ****************************************
    always #10 clk = ~clk;

    wdsp_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .slow_osc_clk(slow_osc_clk),
        .option_byte(option_byte), .wait_mode(wait_mode), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wdt_reset(wdt_reset),
        .prot_on(prot_on), .all_clock_stop(all_clock_stop), .slow_osc_stop(slow_osc_stop));

    // counts chip reset requests; the design is not reset by them here
    always @(posedge clk) begin
        if (wdt_reset === 1'b1) begin
            n_rst <= n_rst + 1;
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // step off the edge so callers see the registered result settled
        #1;
    endtask

    // read data is looked at only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, {4'h0, exp}, {4'h0, rdata});
    endtask

    task automatic cnt_chk(input logic [11:0] exp);
        rd_chk("count lo", ADDR_COUNT_LO, exp[7:0]);
        rd_chk("count hi", ADDR_COUNT_HI, {4'h0, exp[11:8]});
    endtask

    // slow pin held high 3 clk and low 4 clk, longer than the filter needs
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk) slow_osc_clk <= 1'b1;
            repeat (3) @(posedge clk);
            slow_osc_clk <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic do_reset(input logic [7:0] opt);
        @(posedge clk);
        rst_n <= 1'b0;
        option_byte <= opt;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        do_reset(8'hff);
        check("prot off", 12'h000, {11'h0, prot_on});
        rd_chk("option", ADDR_OPTION, 8'hff);
        wr_reg(ADDR_OPTION, 8'h00);
        rd_chk("option kept", ADDR_OPTION, 8'hff);
        tick(5);
        cnt_chk(12'hfff);
        wr_reg(ADDR_START, 8'h01);
        tick(5);
        cnt_chk(12'hffa);
        wr_reg(ADDR_REFRESH, REFRESH_SECOND);
        cnt_chk(12'hffa);
        wr_reg(ADDR_REFRESH, REFRESH_FIRST);
        wr_reg(ADDR_REFRESH, REFRESH_SECOND);
        cnt_chk(12'hfff);
        rd_chk("refresh stat", ADDR_IRQ_STAT, 8'h02);
        wr_reg(ADDR_IRQ_STAT, 8'h02);
        $display("test counting done");

        // unprotected: slow stop accepted; then entering protection undoes it
        wr_reg(ADDR_CLK_MODE1, 8'h10);
        check("slow stop set", 12'h001, {11'h0, slow_osc_stop});
        tick(4);
        cnt_chk(12'hffb);
        wr_reg(ADDR_IRQ_MASK, 8'h04);
        wr_reg(ADDR_PROT_CTRL, 8'h80);
        @(posedge clk);
        #1;
        check("prot on", 12'h001, {11'h0, prot_on});
        check("slow stop cleared", 12'h000, {11'h0, slow_osc_stop});
        rd_chk("reset select", ADDR_PROC_MODE1, 8'h04);
        cnt_chk(12'hfff);
        wait_mode <= 1'b1;
        tick(2);
        cnt_chk(12'hffd);
        wr_reg(ADDR_CLK_MODE1, 8'h11);
        check("all stop", 12'h000, {11'h0, all_clock_stop});
        check("slow stop", 12'h000, {11'h0, slow_osc_stop});
        @(posedge clk);
        #1;
        check("irq blocked", 12'h001, {11'h0, irq});
        rd_chk("blocked stat", ADDR_IRQ_STAT, 8'h04);
        wr_reg(ADDR_IRQ_STAT, 8'h04);
        @(posedge clk);
        #1;
        check("irq cleared", 12'h000, {11'h0, irq});
        $display("test protection done");

        // from ffd the tick at count zero is the 4094th
        tick(4093);
        check("no early reset", 12'h000, n_rst[11:0]);
        tick(1);
        check("underflow reset", 12'h001, n_rst[11:0]);
        cnt_chk(12'hfff);
        rd_chk("no uf irq", ADDR_IRQ_STAT, 8'h00);
        $display("test underflow done");

        // forced protection and autostart from the option byte
        wait_mode <= 1'b0;
        do_reset(8'h7e);
        check("forced prot", 12'h001, {11'h0, prot_on});
        tick(3);
        cnt_chk(12'hffc);
        // clock enable low freezes counter and pin filter alike
        ce <= 1'b0;
        tick(2);
        ce <= 1'b1;
        cnt_chk(12'hffc);
        $display("test option start done");
        give_verdict();
    end

    // watchdog: the tests need about 29000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule

bind wdsp_top wdsp_chk u_chk (.clk(clk), .rst_n(rst_n), .option_byte(option_byte),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wdt_reset(wdt_reset),
    .prot_on(prot_on), .all_clock_stop(all_clock_stop), .slow_osc_stop(slow_osc_stop));
`default_nettype wire
